// [logic/cmf_pkg.sv]
// Purpose: Constants and types of the CAN mode and filter block
// Assumes: Avalon-MM slave, 32-bit data, word-aligned byte addresses
// Notes: Offsets are byte addresses
package cmf_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [9:0] OFS_CONTROL = 10'h000;
   localparam logic [9:0] OFS_STATUS = 10'h004;
   localparam logic [9:0] OFS_ERRFLAG = 10'h008;
   localparam logic [9:0] OFS_CLKSEL = 10'h00c;
   localparam logic [9:0] OFS_BITCFG = 10'h010;
   localparam logic [9:0] OFS_MASKINV = 10'h014;
   localparam logic [9:0] OFS_FILTER = 10'h018;
   localparam logic [9:0] OFS_FIDCR0 = 10'h040;
   localparam logic [9:0] OFS_MASK0 = 10'h060;
   localparam logic [9:0] OFS_MBOX0 = 10'h100;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CTL_MODE_LO = 0;
   localparam int CTL_SLEEP = 2;
   localparam int CTL_BOM_LO = 3;
   localparam int CTL_RECOV = 5;
   localparam int CTL_ID_FORMAT_SELECT_LO = 6;
   localparam int CTL_FIFO = 8;
   localparam int CTL_TEST_LO = 9;
   localparam int ST_RESET = 0;
   localparam int ST_HALT = 1;
   localparam int ST_SLEEP = 2;
   localparam int ST_ACTIVE = 3;
   localparam int ST_BUSOFF = 4;
   localparam int ST_SUB_LO = 5;
   localparam int ST_OWNRX = 7;
   localparam int EF_RECOVERED = 0;
   localparam int ID_RTR = 29;
   localparam int ID_IDE = 30;
   localparam int BRP_W = 10;
   localparam int RECESSIVE_RUN = 11;
   localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
   // ------------------------------------------------------------
   // Encodings
   // ------------------------------------------------------------
   localparam logic [1:0] MODE_OPER = 2'b00;
   localparam logic [1:0] MODE_RESET = 2'b01;
   localparam logic [1:0] MODE_HALT = 2'b10;
   localparam logic [1:0] BOM_NORMAL = 2'b00;
   localparam logic [1:0] BOM_HALT_ENTRY = 2'b01;
   localparam logic [1:0] BOM_HALT_END = 2'b10;
   localparam logic [1:0] BOM_HALT_PROG = 2'b11;
   localparam logic [1:0] ID_FORMAT_SELECT_MIXED = 2'b10;
   typedef enum logic [2:0] {
      CMF_SLEEP = 3'b000,
      CMF_RESET = 3'b001,
      CMF_HALT = 3'b010,
      CMF_JOIN = 3'b011,
      CMF_ACTIVE = 3'b100,
      CMF_BUSOFF = 3'b101
   } cmf_state_t;
   // Frame offered for acceptance by the protocol engine
   typedef struct packed {
      logic [28:0] id;
      logic id_extension_bit;
      logic frame_type_bit;
   } cmf_frame_t;
   // Protocol engine events and state
   typedef struct packed {
      logic bit_tick;
      logic bit_recessive;
      logic busoff_enter;
      logic recovery_done;
      logic [1:0] submode;
      logic own_rx;
   } cmf_link_t;
endpackage

// [logic/cmf_mode_filter.sv]
// Purpose: CAN mode control, prescaler and acceptance filter
// Assumes: Protocol engine events and frames arrive on ref_clk
// Notes: Sleep gates the quantum clock enable; registers reach software over Avalon-MM
//
// The placing of the registers and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
//
// Contract
// - Reset comes up asleep, quantum clock stopped
// - Sleep request enters sleep from reset or halt, status confirms
// - Asleep: only sleep bit writable, reads allowed
// - Clearing sleep request leaves sleep, registers kept
// - Mode 00b enters operation, flags kept
// - Active only after eleven recessive bits
// - Three submodes; own receive in self-test
// - Bus-off freezes all but status/error registers and control mode, sleep and recovery bits
// - Policy 00b: recover, active, set recovered flag
// - Forced recovery: rejoin after eleven recessive bits, no recovered flag
// - Policy 01b: halt at bus-off entry
// - Policy 10b: halt after recovery, flag set
// - Policy 11b: halt on program request
// - Quantum clock is source divided by P+1
// - 32 mailboxes, 8 masks, 2 FIFO compares
// - Mask k covers mailboxes 4k to 4k+3
// - FIFO mode: FIFO uses masks 6 and 7
// - Mask-invalid disables filtering, not for FIFO
// - FIFO matches either set, ignores mailbox IDs
// - Mode 01b reset, 10b halt, confirmed
module cmf_mode_filter #(
   parameter int NUM_MB = 32,
   parameter int NUM_MASK = 8,
   parameter int NUM_FID = 2
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [9:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic can_clk_a,
   input wire logic can_clk_b,
   input wire cmf_pkg::cmf_link_t link,
   input wire logic frame_valid,
   input wire cmf_pkg::cmf_frame_t frame,
   output logic tq_tick,
   output logic node_active,
   output logic accept_valid,
   output logic accept_hit,
   output logic [4:0] accept_mb
);
   // ------------------------------------------------------------
   // State and registers
   // ------------------------------------------------------------
   cmf_pkg::cmf_state_t state;
   logic [1:0] mode_select;
   logic sleep_request;
   logic [1:0] busoff_policy;
   logic [1:0] id_format_select;
   logic fifo_mode;
   logic [1:0] test_mode_select;
   logic forced_recovery;
   logic busoff_recovered_flag;
   logic clock_source_select;
   logic [cmf_pkg::BRP_W-1:0] prescaler_value;
   logic [NUM_MB-1:0] mask_invalid_reg;
   logic [NUM_MB-1:0] mb_rx_en;
   logic [30:0] mailbox_reg [NUM_MB];
   logic [28:0] group_mask_reg [NUM_MASK];
   logic [30:0] fifo_id_compare_reg [NUM_FID];
   logic [3:0] run_cnt;
   logic [cmf_pkg::BRP_W-1:0] pre_cnt;
   logic clk_a_s1, clk_a_s2, clk_a_s3, clk_b_s1, clk_b_s2, clk_b_s3;
   logic ack;
   logic wr, rd;
   logic [31:0] next_rdata;
   logic frozen;

   // One wait; a write lands where waitrequest is low
   assign avs_waitrequest = (avs_read | avs_write) & ~ack;
   assign wr = avs_write & ack;
   assign rd = avs_read & ~ack;
   // Asleep or bus-off: config writes dropped
   assign frozen = (state == cmf_pkg::CMF_SLEEP) | (state == cmf_pkg::CMF_BUSOFF);

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic id_match(input logic [28:0] a, input logic [28:0] b, input logic [28:0] m,
                                     input logic std);
      logic [28:0] mm;
      mm = m;
      if (std) begin
         mm[17:0] = 18'h00000;
      end
      return ((a ^ b) & mm) == 29'h0000_0000;
   endfunction

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ack <= 1'b0;
      end else begin
         ack <= (avs_read | avs_write) & ~ack;
      end
   end

   // ------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------
   logic [31:0] ctl_cur, ctl_new;
   assign ctl_cur = {21'h000000, test_mode_select, fifo_mode, id_format_select, 1'b0, busoff_policy,
                     sleep_request, mode_select};
   assign ctl_new = merge(ctl_cur, avs_writedata, avs_byteenable);
   logic ctl_wr;
   assign ctl_wr = wr & (avs_address == cmf_pkg::OFS_CONTROL);

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         sleep_request <= 1'b1;
         mode_select <= cmf_pkg::MODE_RESET;
         busoff_policy <= cmf_pkg::BOM_NORMAL;
         id_format_select <= 2'b00;
         fifo_mode <= 1'b0;
         test_mode_select <= 2'b00;
      end else if (ctl_wr) begin
         sleep_request <= ctl_new[cmf_pkg::CTL_SLEEP];
         if (state != cmf_pkg::CMF_SLEEP) begin
            mode_select <= ctl_new[cmf_pkg::CTL_MODE_LO +: 2];
            if (state != cmf_pkg::CMF_BUSOFF) begin
               busoff_policy <= ctl_new[cmf_pkg::CTL_BOM_LO +: 2];
               id_format_select <= ctl_new[cmf_pkg::CTL_ID_FORMAT_SELECT_LO +: 2];
               fifo_mode <= ctl_new[cmf_pkg::CTL_FIFO];
               test_mode_select <= ctl_new[cmf_pkg::CTL_TEST_LO +: 2];
            end
         end
      end else if (state == cmf_pkg::CMF_BUSOFF && busoff_policy == cmf_pkg::BOM_HALT_ENTRY) begin
         mode_select <= cmf_pkg::MODE_HALT;
      end else if (state == cmf_pkg::CMF_BUSOFF && link.recovery_done && !forced_recovery &&
                   busoff_policy == cmf_pkg::BOM_HALT_END) begin
         mode_select <= cmf_pkg::MODE_HALT;
      end
   end

   // Forced recovery strobe, self-clearing after one cycle
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         forced_recovery <= 1'b0;
      end else if (ctl_wr && state == cmf_pkg::CMF_BUSOFF && ctl_new[cmf_pkg::CTL_RECOV]) begin
         forced_recovery <= 1'b1;
      end else begin
         forced_recovery <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Mode state machine
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state <= cmf_pkg::CMF_SLEEP;
      end else begin
         case (state)
            cmf_pkg::CMF_SLEEP: begin
               if (!sleep_request) begin
                  state <= (mode_select == cmf_pkg::MODE_HALT) ? cmf_pkg::CMF_HALT : cmf_pkg::CMF_RESET;
               end
            end
            cmf_pkg::CMF_RESET, cmf_pkg::CMF_HALT: begin
               if (sleep_request) begin
                  state <= cmf_pkg::CMF_SLEEP;
               end else if (mode_select == cmf_pkg::MODE_OPER) begin
                  state <= cmf_pkg::CMF_JOIN;
               end else if (mode_select == cmf_pkg::MODE_HALT) begin
                  state <= cmf_pkg::CMF_HALT;
               end else begin
                  state <= cmf_pkg::CMF_RESET;
               end
            end
            cmf_pkg::CMF_JOIN, cmf_pkg::CMF_ACTIVE: begin
               if (mode_select == cmf_pkg::MODE_RESET) begin
                  state <= cmf_pkg::CMF_RESET;
               end else if (mode_select == cmf_pkg::MODE_HALT) begin
                  state <= cmf_pkg::CMF_HALT;
               end else if (state == cmf_pkg::CMF_ACTIVE && link.busoff_enter) begin
                  state <= cmf_pkg::CMF_BUSOFF;
               end else if (state == cmf_pkg::CMF_JOIN && link.bit_tick && link.bit_recessive &&
                            run_cnt == 4'(cmf_pkg::RECESSIVE_RUN - 1)) begin
                  state <= cmf_pkg::CMF_ACTIVE;
               end
            end
            cmf_pkg::CMF_BUSOFF: begin
               // Reset request leaves without waiting for recovery
               if (mode_select == cmf_pkg::MODE_RESET) begin
                  state <= cmf_pkg::CMF_RESET;
               end else if (busoff_policy == cmf_pkg::BOM_HALT_ENTRY) begin
                  state <= cmf_pkg::CMF_HALT;
               end else if (mode_select == cmf_pkg::MODE_HALT && busoff_policy == cmf_pkg::BOM_HALT_PROG) begin
                  state <= cmf_pkg::CMF_HALT;
               end else if (forced_recovery) begin
                  state <= cmf_pkg::CMF_JOIN;
               end else if (link.recovery_done) begin
                  state <= (busoff_policy == cmf_pkg::BOM_HALT_END) ? cmf_pkg::CMF_HALT
                                                                    : cmf_pkg::CMF_ACTIVE;
               end
            end
            default: state <= cmf_pkg::CMF_SLEEP;
         endcase
      end
   end

   // Recessive run counter for joining the bus
   always_ff @(posedge ref_clk) begin
      if (!rst_n || state != cmf_pkg::CMF_JOIN) begin
         run_cnt <= 4'h0;
      end else if (link.bit_tick) begin
         run_cnt <= link.bit_recessive ? run_cnt + 4'h1 : 4'h0;
      end
   end

   // Recovered flag; set wins over a software clear
   logic recov_set;
   assign recov_set = (state == cmf_pkg::CMF_BUSOFF) && link.recovery_done && !forced_recovery &&
                      (busoff_policy != cmf_pkg::BOM_HALT_ENTRY) &&
                      !(busoff_policy == cmf_pkg::BOM_HALT_PROG && mode_select == cmf_pkg::MODE_HALT);
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         busoff_recovered_flag <= 1'b0;
      end else if (recov_set) begin
         busoff_recovered_flag <= 1'b1;
      end else if (wr && avs_address == cmf_pkg::OFS_ERRFLAG && avs_byteenable[0] &&
                   !avs_writedata[cmf_pkg::EF_RECOVERED] && state != cmf_pkg::CMF_SLEEP) begin
         busoff_recovered_flag <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Clock selection and prescaler
   // ------------------------------------------------------------
   // Source clocks are sampled; edges become enables
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         {clk_a_s1, clk_a_s2, clk_a_s3} <= 3'h0;
         {clk_b_s1, clk_b_s2, clk_b_s3} <= 3'h0;
      end else begin
         {clk_a_s1, clk_a_s2, clk_a_s3} <= {can_clk_a, clk_a_s1, clk_a_s2};
         {clk_b_s1, clk_b_s2, clk_b_s3} <= {can_clk_b, clk_b_s1, clk_b_s2};
      end
   end
   logic src_edge;
   assign src_edge = clock_source_select ? (clk_b_s2 & ~clk_b_s3) : (clk_a_s2 & ~clk_a_s3);

   always_ff @(posedge ref_clk) begin
      if (!rst_n || state == cmf_pkg::CMF_SLEEP) begin
         pre_cnt <= '0;
         tq_tick <= 1'b0;
      end else if (src_edge) begin
         tq_tick <= (pre_cnt == prescaler_value);
         pre_cnt <= (pre_cnt >= prescaler_value) ? '0 : pre_cnt + 1'b1;
      end else begin
         tq_tick <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Configuration and filter registers
   // ------------------------------------------------------------
   logic adr_mb, adr_mk, adr_fid;
   assign adr_mb = avs_address >= cmf_pkg::OFS_MBOX0 && avs_address < cmf_pkg::OFS_MBOX0 + 10'(NUM_MB*4);
   assign adr_mk = avs_address >= cmf_pkg::OFS_MASK0 && avs_address < cmf_pkg::OFS_MASK0 + 10'(NUM_MASK*4);
   assign adr_fid = avs_address >= cmf_pkg::OFS_FIDCR0 && avs_address < cmf_pkg::OFS_FIDCR0 + 10'(NUM_FID*4);
   logic [4:0] widx;
   assign widx = avs_address[6:2];

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         clock_source_select <= 1'b0;
         prescaler_value <= '0;
         mask_invalid_reg <= '0;
         mb_rx_en <= '0;
      end else if (wr && !frozen) begin
         if (avs_address == cmf_pkg::OFS_CLKSEL && avs_byteenable[0]) begin
            clock_source_select <= avs_writedata[0];
         end
         if (avs_address == cmf_pkg::OFS_BITCFG) begin
            prescaler_value <= cmf_pkg::BRP_W'(merge(32'(prescaler_value), avs_writedata, avs_byteenable));
         end
         if (avs_address == cmf_pkg::OFS_MASKINV) begin
            mask_invalid_reg <= NUM_MB'(merge(32'(mask_invalid_reg), avs_writedata, avs_byteenable));
         end
         if (avs_address == cmf_pkg::OFS_FILTER) begin
            mb_rx_en <= NUM_MB'(merge(32'(mb_rx_en), avs_writedata, avs_byteenable));
         end
      end
   end

   // Filter arrays keep contents across resets of state
   always_ff @(posedge ref_clk) begin
      if (wr && !frozen) begin
         if (adr_mb) begin
            mailbox_reg[widx] <= 31'(merge(32'(mailbox_reg[widx]), avs_writedata, avs_byteenable));
         end
         if (adr_mk) begin
            group_mask_reg[widx[2:0]] <= 29'(merge(32'(group_mask_reg[widx[2:0]]), avs_writedata, avs_byteenable));
         end
         if (adr_fid) begin
            fifo_id_compare_reg[widx[0]] <= 31'(merge(32'(fifo_id_compare_reg[widx[0]]), avs_writedata,
                                                       avs_byteenable));
         end
      end
   end

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   always_comb begin
      next_rdata = cmf_pkg::RD_UNMAPPED;
      if (avs_address == cmf_pkg::OFS_CONTROL) begin
         next_rdata = ctl_cur;
      end else if (avs_address == cmf_pkg::OFS_STATUS) begin
         next_rdata[cmf_pkg::ST_RESET] = (state == cmf_pkg::CMF_RESET);
         next_rdata[cmf_pkg::ST_HALT] = (state == cmf_pkg::CMF_HALT);
         next_rdata[cmf_pkg::ST_SLEEP] = (state == cmf_pkg::CMF_SLEEP);
         next_rdata[cmf_pkg::ST_ACTIVE] = node_active;
         next_rdata[cmf_pkg::ST_BUSOFF] = (state == cmf_pkg::CMF_BUSOFF);
         next_rdata[cmf_pkg::ST_SUB_LO +: 2] = node_active ? link.submode : 2'b00;
         next_rdata[cmf_pkg::ST_OWNRX] = node_active && test_mode_select[1] && link.own_rx;
      end else if (avs_address == cmf_pkg::OFS_ERRFLAG) begin
         next_rdata[cmf_pkg::EF_RECOVERED] = busoff_recovered_flag;
      end else if (avs_address == cmf_pkg::OFS_CLKSEL) begin
         next_rdata[0] = clock_source_select;
      end else if (avs_address == cmf_pkg::OFS_BITCFG) begin
         next_rdata = 32'(prescaler_value);
      end else if (avs_address == cmf_pkg::OFS_MASKINV) begin
         next_rdata = 32'(mask_invalid_reg);
      end else if (avs_address == cmf_pkg::OFS_FILTER) begin
         next_rdata = 32'(mb_rx_en);
      end else if (adr_mb) begin
         next_rdata = 32'(mailbox_reg[widx]);
      end else if (adr_mk) begin
         next_rdata = 32'(group_mask_reg[widx[2:0]]);
      end else if (adr_fid) begin
         next_rdata = 32'(fifo_id_compare_reg[widx[0]]);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         avs_readdata <= '0;
      end else if (rd) begin
         avs_readdata <= next_rdata;
      end
   end

   // ------------------------------------------------------------
   // Acceptance filter
   // ------------------------------------------------------------
   logic [NUM_MB-1:0] hit;
   logic fifo_hit;
   always_comb begin
      logic fmt_ok;
      logic [28:0] m;
      fmt_ok = 1'b0;
      m = '0;
      for (int j = 0; j < NUM_MB; j++) begin
         m = mask_invalid_reg[j] ? 29'h0000_0000 : group_mask_reg[j/4];
         fmt_ok = (id_format_select == cmf_pkg::ID_FORMAT_SELECT_MIXED) ? (mailbox_reg[j][cmf_pkg::ID_IDE] == frame.id_extension_bit)
                                                            : (id_format_select[0] == frame.id_extension_bit);
         hit[j] = mb_rx_en[j] && fmt_ok && mailbox_reg[j][cmf_pkg::ID_RTR] == frame.frame_type_bit &&
                  id_match(frame.id, mailbox_reg[j][28:0], m, !frame.id_extension_bit);
      end
      // FIFO owns mailboxes 24..31; 24..27 hold the transmit side
      if (fifo_mode) begin
         hit[NUM_MB-1:NUM_MB-8] = '0;
      end
      fifo_hit = 1'b0;
      for (int n = 0; n < NUM_FID; n++) begin
         fifo_hit = fifo_hit | (fifo_id_compare_reg[n][cmf_pkg::ID_IDE] == frame.id_extension_bit &&
                                fifo_id_compare_reg[n][cmf_pkg::ID_RTR] == frame.frame_type_bit &&
                                id_match(frame.id, fifo_id_compare_reg[n][28:0], group_mask_reg[NUM_MASK-2+n],
                                         !frame.id_extension_bit));
      end
   end

   // Lowest-numbered matching mailbox wins
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         accept_valid <= 1'b0;
         accept_hit <= 1'b0;
         accept_mb <= 5'h00;
      end else begin
         accept_valid <= frame_valid && node_active;
         accept_hit <= 1'b0;
         accept_mb <= 5'h00;
         if (frame_valid && node_active) begin
            for (int j = NUM_MB - 1; j >= 0; j--) begin
               if (hit[j] || (fifo_mode && fifo_hit && j == NUM_MB - 4)) begin
                  accept_hit <= 1'b1;
                  accept_mb <= 5'(j);
               end
            end
         end
      end
   end

   assign node_active = (state == cmf_pkg::CMF_ACTIVE);
endmodule
`default_nettype wire

// [sim/cmf_mode_filter_asserts.sv]
// Purpose: Port-level checks for cmf_mode_filter
// Assumes: One clock domain, synchronous active-low reset
// Notes: Bound to every instance at the foot of this file
`timescale 1ns/1ns
`default_nettype none
module cmf_mode_filter_chk (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire cmf_pkg::cmf_link_t link,
   input wire logic frame_valid,
   input wire logic tq_tick,
   input wire logic node_active,
   input wire logic accept_valid,
   input wire logic accept_hit
);
   logic [3:0] run;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // Saturating recessive-bit run
   always_ff @(posedge ref_clk) begin
      if (!rst_n || (link.bit_tick && !link.bit_recessive))
         run <= 4'h0;
      else if (link.bit_tick && run != 4'hf)
         run <= run + 4'h1;
   end
   sequence s_take; (avs_read || avs_write) && avs_waitrequest; endsequence
   sequence s_offer; frame_valid && node_active; endsequence
   property p_one_wait; s_take |=> !avs_waitrequest; endproperty
   a_one_wait: assert property (p_one_wait) else $error("late bus answer");
   property p_reset_quiet; !$past(rst_n) |-> !node_active && !tq_tick; endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("busy out of reset");
   property p_join; $rose(node_active) |-> run >= 4'd11 || $past(link.recovery_done); endproperty
   a_join: assert property (p_join) else $error("early join");
   property p_busoff_drop; link.busoff_enter |=> !node_active; endproperty
   a_busoff_drop: assert property (p_busoff_drop) else $error("active in bus-off");
   property p_tick_pulse; tq_tick |=> !tq_tick; endproperty
   a_tick_pulse: assert property (p_tick_pulse) else $error("long tick");
   property p_accept; s_offer |=> accept_valid; endproperty
   a_accept: assert property (p_accept) else $error("frame not judged");
   property p_accept_cause; accept_valid |-> $past(frame_valid) && $past(node_active); endproperty
   a_accept_cause: assert property (p_accept_cause) else $error("stray judgement");
   property p_hit_valid; accept_hit |-> accept_valid; endproperty
   a_hit_valid: assert property (p_hit_valid) else $error("hit outside judgement");
endmodule
bind cmf_mode_filter cmf_mode_filter_chk u_chk (.*);
`default_nettype wire

// [sim/cmf_bus_model.sv]
// Purpose: Far-side bus and protocol engine stand-in
// Assumes: Bench commands bus-off entry and recovery as one-cycle pulses
// Notes: Source clocks are ref_clk divided by 4 and 8
`timescale 1ns/1ns
`default_nettype none
module cmf_bus_model #(
   parameter int BIT_CYC = 5
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic go_busoff,
   input wire logic go_recover,
   output cmf_pkg::cmf_link_t link,
   output logic can_clk_a,
   output logic can_clk_b
);
   logic [7:0] cyc;
   logic [3:0] div;
   always_ff @(posedge ref_clk) begin
      cyc <= (!rst_n || cyc == 8'(BIT_CYC - 1)) ? 8'h0 : cyc + 8'h1;
   end
   always_ff @(posedge ref_clk) begin
      div <= rst_n ? div + 4'h1 : 4'h0;
   end
   assign can_clk_a = div[1];
   assign can_clk_b = div[2];
   always_comb begin
      link = '0;
      link.bit_tick = rst_n && cyc == 8'h0;
      link.bit_recessive = 1'b1; // Idle bus sits recessive
      link.busoff_enter = go_busoff;
      link.recovery_done = go_recover;
   end
endmodule
`default_nettype wire

// [sim/tb_cmf_mode_filter.sv]
// Purpose: Self-checking bench for cmf_mode_filter
// Assumes: Slave answers by waitrequest
// Notes: Expected results are queued
`timescale 1ns/1ns
`default_nettype none
module tb_cmf_mode_filter;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [9:0] avs_address = 10'h000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, seed, prs, standard_id_field;
   logic avs_waitrequest, can_clk_a, can_clk_b, tq_tick, node_active, accept_valid, accept_hit;
   logic frame_valid = 1'b0;
   logic go_busoff = 1'b0;
   logic go_recover = 1'b0;
   logic [4:0] accept_mb;
   cmf_pkg::cmf_frame_t frame = '0;
   cmf_pkg::cmf_link_t link;
   logic [31:0] exp_q[$];
   int n_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   cmf_mode_filter u_dut (.*, .avs_byteenable(4'hf));
   cmf_bus_model u_bus (.*);
   initial begin
      forever #20 ref_clk = ~ref_clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d errors=%0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic bus(input logic rd, input logic [9:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      avs_address <= a;
      avs_read <= rd;
      avs_write <= !rd;
      avs_writedata <= d;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rd(input logic [9:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b1, a, 32'h0);
   endtask
   task automatic send(input logic [28:0] id, input logic [31:0] e);
      exp_q.push_back(e);
      @(posedge ref_clk);
      frame <= {id, 2'b00};
      frame_valid <= 1'b1;
      @(posedge ref_clk);
      frame_valid <= 1'b0;
   endtask
   task automatic pulse(input logic rec);
      @(posedge ref_clk);
      go_busoff <= !rec;
      go_recover <= rec;
      @(posedge ref_clk);
      go_busoff <= 1'b0;
      go_recover <= 1'b0;
   endtask
   task automatic tq_gap(input logic [31:0] e);
      int n;
      @(posedge ref_clk iff tq_tick === 1'b1);
      @(posedge ref_clk);
      for (n = 1; tq_tick !== 1'b1; n++)
         @(posedge ref_clk);
      check(32'(n), e);
   endtask
   task automatic wait_active();
      for (int n = 0; n < 200 && node_active !== 1'b1; n++)
         @(posedge ref_clk);
      check({31'h0, node_active}, 32'h1);
   endtask
   // ------------------------------------------------------------
   // Result watcher and hang limit
   // ------------------------------------------------------------
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles > 20000) begin
         n_errors++;
         tally_and_finish();
      end
      if ((avs_read === 1'b1 && avs_waitrequest === 1'b0) || accept_valid === 1'b1)
         check(avs_read ? avs_readdata : {26'h0, accept_hit, accept_hit ? accept_mb : 5'h0}, exp_q.pop_front());
   end
   initial begin
      seed = xs(32'h76e4e278);
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(cmf_pkg::OFS_STATUS, 32'h4);
      bus(1'b0, cmf_pkg::OFS_CONTROL, 32'h6);
      rd(cmf_pkg::OFS_CONTROL, 32'h5);
      bus(1'b0, cmf_pkg::OFS_CONTROL, 32'h1);
      rd(cmf_pkg::OFS_STATUS, 32'h1);
      rd(10'h3fc, cmf_pkg::RD_UNMAPPED);
      prs = {30'h0, seed[1:0]};
      standard_id_field = {3'h0, seed[12:2], 18'h0};
      bus(1'b0, cmf_pkg::OFS_BITCFG, prs);
      for (int s = 0; s < 2; s++) begin
         bus(1'b0, cmf_pkg::OFS_CLKSEL, 32'(s));
         tq_gap(32'(s + 1) * 32'h4 * (prs + 32'h1));
      end
      bus(1'b0, cmf_pkg::OFS_MASK0, 32'h1fff_ffff);
      bus(1'b0, cmf_pkg::OFS_MBOX0, ~standard_id_field & 32'h1fff_ffff);
      bus(1'b0, cmf_pkg::OFS_MBOX0 + 10'h4, standard_id_field);
      bus(1'b0, cmf_pkg::OFS_MASKINV, 32'h0);
      bus(1'b0, cmf_pkg::OFS_FILTER, 32'h3);
      bus(1'b0, cmf_pkg::OFS_CONTROL, 32'h0);
      check({31'h0, node_active}, 32'h0);
      wait_active();
      rd(cmf_pkg::OFS_STATUS, 32'h8);
      send(standard_id_field[28:0], 32'h21);
      send(standard_id_field[28:0] ^ 29'h40000, 32'h0);
      bus(1'b0, cmf_pkg::OFS_MASKINV, 32'h1);
      send(standard_id_field[28:0] ^ 29'h40000, 32'h20);
      pulse(1'b0);
      bus(1'b0, cmf_pkg::OFS_BITCFG, prs ^ 32'h1);
      pulse(1'b1);
      rd(cmf_pkg::OFS_BITCFG, prs);
      rd(cmf_pkg::OFS_ERRFLAG, 32'h1);
      wait_active();
      bus(1'b0, cmf_pkg::OFS_ERRFLAG, 32'h0);
      bus(1'b0, cmf_pkg::OFS_CONTROL, 32'ha);
      rd(cmf_pkg::OFS_STATUS, 32'h2);
      bus(1'b0, cmf_pkg::OFS_CONTROL, 32'h8);
      wait_active();
      pulse(1'b0);
      rd(cmf_pkg::OFS_STATUS, 32'h2);
      rd(cmf_pkg::OFS_ERRFLAG, 32'h0);
      repeat (3) @(posedge ref_clk);
      tally_and_finish();
   end
endmodule
`default_nettype wire
